//--- include/udsr_pkg.sv
// Notes on behaviour
// - Raise terminal ramps output up to the upper limit, then stops.
// - Lower terminal ramps output down to the lower limit, then stops.
// - With neither terminal active the present ramp value is kept.
// - Upward slope from acceleration time, downward slope from deceleration time.
// - Disable terminal gates the block; activation loads the assigned input signal.
// - A loaded value outside the limits ramps to the violated limit.
// - Deactivation action 0 leaves the output where it is.
// - Actions 1, 2, 5 ramp to zero, lower limit, upper limit.
// - Actions 3 and 4 jump to zero or lower limit at once.
// - At power-off the present output is written to nonvolatile memory.
// - At start-up init select picks saved value or lower limit.
// - Sample-and-hold: deactivation freezes output against analog input changes.
// - Sample-and-hold mode disables up/down set-value operation.
// - Sample-and-hold start-up follows deactivation action and init select; the code applies init select only, never the deactivation action.
// - Ramp times are 0 to 100 percent, 1 s to 5000 s, default 10 s.
// - Output is signed, 14-bit resolution, -16384 to +16384.
package udsr_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_UPPER  = 8'h00;
  localparam logic [7:0] OFS_LOWER  = 8'h04;
  localparam logic [7:0] OFS_ACCEL  = 8'h08;
  localparam logic [7:0] OFS_DECEL  = 8'h0c;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] OFS_OUTPUT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int LIM_W       = 11;
  localparam int TIME_W      = 13;
  localparam int OUT_W       = 16;
  localparam int CFG_ACT_LSB = 0;
  localparam int CFG_INIT    = 3;
  localparam int CFG_SH      = 4;
  localparam int STS_ACTIVE  = 0;
  localparam int STS_RAMP    = 1;
  localparam int STS_READY   = 2;

  // ----------------------------------------
  // Reset values and ranges
  // ----------------------------------------
  localparam logic [LIM_W-1:0]  UPPER_RST = 11'h3e8;
  localparam logic [LIM_W-1:0]  LOWER_RST = 11'h000;
  localparam logic [TIME_W-1:0] TIME_RST  = 13'h000a;
  localparam logic [TIME_W-1:0] TIME_MIN  = 13'h0001;
  localparam logic [TIME_W-1:0] TIME_MAX  = 13'h1388;

  // Deactivation actions
  localparam logic [2:0] ACT_KEEP    = 3'h0;
  localparam logic [2:0] ACT_RAMP0   = 3'h1;
  localparam logic [2:0] ACT_RAMPLO  = 3'h2;
  localparam logic [2:0] ACT_JUMP0   = 3'h3;
  localparam logic [2:0] ACT_JUMPLO  = 3'h4;
  localparam logic [2:0] ACT_RAMPHI  = 3'h5;

  // ----------------------------------------
  // Timing and scaling
  // ----------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int SEC_TO_CYCLES = CLK_HZ / 1;
  localparam logic [39:0] FULL_SCALE = 40'h0000004000;
  localparam logic signed [25:0] LIM_MUL   = 26'sh0004189;
  localparam logic signed [25:0] LIM_ROUND = 26'sh0000200;
  localparam int LIM_SHIFT = 10;

  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_OFF_RAMP, ST_OFF_HOLD} udsr_mode_t;

  // Limit in 0.1 % steps to output counts, 1000 maps to 16384
  function automatic logic [OUT_W-1:0] udsr_scale(input logic [LIM_W-1:0] lim);
    logic signed [25:0] prod;
    prod = 26'($signed(lim)) * LIM_MUL + LIM_ROUND;
    prod = prod >>> LIM_SHIFT;
    return prod[OUT_W-1:0];
  endfunction

endpackage

//--- design/udsr_sync.sv
`timescale 1ns/1ps
module udsr_sync
  import udsr_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  if (WIDTH < 1) begin : g_chk
    $error("udsr_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } udsr_sync_t;

  udsr_sync_t sync_reg;
  udsr_sync_t sync_next;

  // ----------------------------------------
  // Two stages; only stage two is seen outside
  // ----------------------------------------
  always_comb
  begin
    sync_next.meta   = i_async;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      sync_reg <= '0;
    else
      sync_reg <= sync_next;
  end

  assign o_sync = sync_reg.stable;

endmodule

//--- design/udsr_step.sv
`timescale 1ns/1ps
module udsr_step
  import udsr_pkg::*;
#(
  parameter int P_CYCLES_PER_SEC = SEC_TO_CYCLES
)
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  // Ramp request and full-scale time in seconds
  input  wire logic              i_run,
  input  wire logic [TIME_W-1:0] i_time,
  // One count step
  output logic                   o_step
);

  // Fastest ramp must still give at most one count per cycle
  if (P_CYCLES_PER_SEC < 16384) begin : g_chk
    $error("udsr_step: P_CYCLES_PER_SEC must be at least 16384");
  end

  localparam logic [39:0] CYC = 40'(P_CYCLES_PER_SEC);

  typedef struct packed {
    logic [39:0] acc;
    logic        step;
  } udsr_step_t;

  udsr_step_t st_reg;
  udsr_step_t st_next;
  logic [39:0] thr;
  logic [39:0] sum;

  // ----------------------------------------
  // Fractional accumulator: 16384 counts per full time
  // ----------------------------------------
  always_comb
  begin
    thr          = 40'(i_time) * CYC;
    sum          = st_reg.acc + FULL_SCALE;
    st_next.step = 1'b0;
    st_next.acc  = sum;
    if (!i_run)
    begin
      st_next.acc = '0; // Restart phase so each ramp starts clean
    end
    else if (sum >= thr)
    begin
      st_next.acc  = sum - thr;
      st_next.step = 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_step = st_reg.step;

endmodule

//--- design/udsr_top.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module udsr_top
  import udsr_pkg::*;
#(
  parameter int P_CYCLES_PER_SEC = SEC_TO_CYCLES
)
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Terminal pins, asynchronous
  input  wire logic              i_raise_pin,
  input  wire logic              i_lower_pin,
  input  wire logic              i_block_disable_terminal,
  input  wire logic              i_power_fail_pin,
  // Assigned analog input, same clock
  input  wire logic [OUT_W-1:0]  i_assignable_analog_input,
  // Nonvolatile memory
  input  wire logic              i_nvm_ready,
  input  wire logic [OUT_W-1:0]  i_nvm_data,
  output logic                   o_nvm_wr_en,
  output logic      [OUT_W-1:0]  o_nvm_wr_data,
  // Set value out
  output logic      [OUT_W-1:0]  o_setpoint,
  output logic                   o_active
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    udsr_mode_t        mode;
    logic              active;
    logic [OUT_W-1:0]  out;
    logic [OUT_W-1:0]  off_tgt;
    logic [LIM_W-1:0]  upper_limit_setting;
    logic [LIM_W-1:0]  lower_limit_setting;
    logic [TIME_W-1:0] accel_time_setting;
    logic [TIME_W-1:0] decel_time_setting;
    logic [2:0]        deactivation_action;
    logic              powerup_init_select;
    logic              analog_source_select;
    logic              dis_prev;
    logic              pf_prev;
    logic              ready;
    logic              nvm_wr_en;
    logic [OUT_W-1:0]  nvm_wr_data;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } udsr_top_t;

  localparam udsr_top_t ST_RST = '{
    mode:                ST_INIT,
    upper_limit_setting: UPPER_RST,
    lower_limit_setting: LOWER_RST,
    accel_time_setting:  TIME_RST,
    decel_time_setting:  TIME_RST,
    dis_prev:            1'b1,
    default:             '0
  };

  udsr_top_t st_reg;
  udsr_top_t st_next;

  logic [3:0]       pins_sync;
  logic             raise_s;
  logic             lower_s;
  logic             dis_s;
  logic             pf_s;
  logic [OUT_W-1:0] upper_cnt;
  logic [OUT_W-1:0] lower_cnt;
  logic [OUT_W-1:0] ramp_tgt;
  logic             ramp_en;
  logic             go_up;
  logic             go_dn;
  logic             step_up;
  logic             step_dn;
  logic             access;
  logic             done;
  logic [31:0]      rd_data;
  logic             rd_err;
  logic [TIME_W-1:0] wr_time;

  // ----------------------------------------
  // Pin synchronisers and ramp rate steppers
  // ----------------------------------------
  udsr_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async ({i_power_fail_pin, i_block_disable_terminal, i_lower_pin, i_raise_pin}),
    .o_sync  (pins_sync)
  );

  assign raise_s = pins_sync[0];
  assign lower_s = pins_sync[1];
  assign dis_s   = pins_sync[2];
  assign pf_s    = pins_sync[3];

  udsr_step #(
    .P_CYCLES_PER_SEC (P_CYCLES_PER_SEC)
  ) u_step_up (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_run   (go_up),
    .i_time  (st_reg.accel_time_setting),
    .o_step  (step_up)
  );

  udsr_step #(
    .P_CYCLES_PER_SEC (P_CYCLES_PER_SEC)
  ) u_step_dn (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_run   (go_dn),
    .i_time  (st_reg.decel_time_setting),
    .o_step  (step_dn)
  );

  // ----------------------------------------
  // Ramp target; limits converted to output counts
  // ----------------------------------------
  always_comb
  begin
    upper_cnt = udsr_scale(st_reg.upper_limit_setting);
    lower_cnt = udsr_scale(st_reg.lower_limit_setting);
    ramp_tgt  = st_reg.out;
    ramp_en   = 1'b0;
    if (st_reg.mode == ST_RUN && !st_reg.analog_source_select)
    begin
      ramp_en = 1'b1;
      if ($signed(st_reg.out) > $signed(upper_cnt))
        ramp_tgt = upper_cnt;
      else if ($signed(st_reg.out) < $signed(lower_cnt))
        ramp_tgt = lower_cnt;
      else if (raise_s && !lower_s)
        ramp_tgt = upper_cnt;
      else if (lower_s && !raise_s)
        ramp_tgt = lower_cnt;
      else
        ramp_en = 1'b0;
    end
    else if (st_reg.mode == ST_OFF_RAMP)
    begin
      ramp_tgt = st_reg.off_tgt;
      ramp_en  = 1'b1;
    end
    go_up = ramp_en && ($signed(st_reg.out) < $signed(ramp_tgt));
    go_dn = ramp_en && ($signed(st_reg.out) > $signed(ramp_tgt));
  end

  // ----------------------------------------
  // APB decode; one wait state, so pready comes from a flop
  // ----------------------------------------
  always_comb
  begin
    access  = i_psel && i_penable && !st_reg.pready;
    done    = i_psel && i_penable && st_reg.pready;
    rd_err  = 1'b0;
    rd_data = '0;
    case (i_paddr)
      OFS_UPPER:  rd_data = {21'h000000, st_reg.upper_limit_setting};
      OFS_LOWER:  rd_data = {21'h000000, st_reg.lower_limit_setting};
      OFS_ACCEL:  rd_data = {19'h00000, st_reg.accel_time_setting};
      OFS_DECEL:  rd_data = {19'h00000, st_reg.decel_time_setting};
      OFS_CONFIG: rd_data = {27'h0000000, st_reg.analog_source_select,
                             st_reg.powerup_init_select, st_reg.deactivation_action};
      OFS_OUTPUT: rd_data = {16'h0000, st_reg.out};
      OFS_STATUS: rd_data = {29'h00000000, st_reg.ready, (go_up || go_dn),
                             (st_reg.mode == ST_RUN)};
      default:    rd_err  = 1'b1;
    endcase
    // Out-of-range times are pulled into 1 s .. 5000 s
    wr_time = i_pwdata[TIME_W-1:0];
    if (i_pwdata[31:TIME_W] != '0 || wr_time > TIME_MAX)
      wr_time = TIME_MAX;
    else if (wr_time < TIME_MIN)
      wr_time = TIME_MIN;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_next           = st_reg;
    st_next.dis_prev  = dis_s;
    st_next.pf_prev   = pf_s;
    st_next.nvm_wr_en = 1'b0;
    st_next.pready    = access;
    st_next.pslverr   = access && rd_err;
    if (access)
      st_next.prdata = rd_data;

    // Register writes take effect at the completing edge
    if (done && i_pwrite)
    begin
      case (i_paddr)
        OFS_UPPER:  st_next.upper_limit_setting = i_pwdata[LIM_W-1:0];
        OFS_LOWER:  st_next.lower_limit_setting = i_pwdata[LIM_W-1:0];
        OFS_ACCEL:  st_next.accel_time_setting  = wr_time;
        OFS_DECEL:  st_next.decel_time_setting  = wr_time;
        OFS_CONFIG:
        begin
          st_next.deactivation_action  = i_pwdata[CFG_ACT_LSB +: 3];
          st_next.powerup_init_select  = i_pwdata[CFG_INIT];
          st_next.analog_source_select = i_pwdata[CFG_SH];
        end
        default: ;
      endcase
    end

    // Power loss edge stores the present value
    if (pf_s && !st_reg.pf_prev && st_reg.ready)
    begin
      st_next.nvm_wr_en   = 1'b1;
      st_next.nvm_wr_data = st_reg.out;
    end

    // One count per rate step, never past the target
    if (go_up && step_up)
      st_next.out = st_reg.out + 16'h0001;
    else if (go_dn && step_dn)
      st_next.out = st_reg.out - 16'h0001;

    case (st_reg.mode)
      ST_INIT:
      begin
        if (i_nvm_ready)
        begin
          st_next.ready = 1'b1;
          st_next.out   = st_reg.powerup_init_select ? lower_cnt : i_nvm_data;
          st_next.mode  = dis_s ? ST_OFF_HOLD : ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (st_reg.analog_source_select)
          st_next.out = i_assignable_analog_input;
        if (dis_s)
        begin
          st_next.mode = ST_OFF_RAMP;
          case (st_reg.deactivation_action)
            ACT_RAMP0:  st_next.off_tgt = '0;
            ACT_RAMPLO: st_next.off_tgt = lower_cnt;
            ACT_RAMPHI: st_next.off_tgt = upper_cnt;
            ACT_JUMP0:
            begin
              st_next.out  = '0;
              st_next.mode = ST_OFF_HOLD;
            end
            ACT_JUMPLO:
            begin
              st_next.out  = lower_cnt;
              st_next.mode = ST_OFF_HOLD;
            end
            default:
            begin
              // Held value no longer tracks the analog input
              st_next.out  = st_reg.analog_source_select ? i_assignable_analog_input : st_reg.out;
              st_next.mode = ST_OFF_HOLD;
            end
          endcase
        end
      end
      ST_OFF_RAMP:
      begin
        if (!go_up && !go_dn)
          st_next.mode = ST_OFF_HOLD;
      end
      ST_OFF_HOLD:
      begin
        // Frozen; no step can reach here since ramp_en is low
      end
      default:
        st_next.mode = ST_INIT;
    endcase

    // Activation loads the assigned signal in every mode except ST_INIT
    if (st_reg.mode != ST_INIT && st_reg.dis_prev && !dis_s)
    begin
      st_next.out  = i_assignable_analog_input;
      st_next.mode = ST_RUN;
    end
    // Run flag kept in its own flop so the pin needs no decode
    st_next.active = (st_next.mode == ST_RUN);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign o_prdata      = st_reg.prdata;
  assign o_pready      = st_reg.pready;
  assign o_pslverr     = st_reg.pslverr;
  assign o_nvm_wr_en   = st_reg.nvm_wr_en;
  assign o_nvm_wr_data = st_reg.nvm_wr_data;
  assign o_setpoint    = st_reg.out;
  assign o_active      = st_reg.active;

endmodule

//--- verification/udsr_checker_properties.sv
`timescale 1ns/1ps
module udsr_checker
  import udsr_pkg::*;
#(parameter int P_CYCLES_PER_SEC = SEC_TO_CYCLES)
(
  // Clock and reset
  input wire logic             i_clock,
  input wire logic             i_rst_b,
  // APB
  input wire logic             i_psel,
  input wire logic             i_penable,
  input wire logic             i_pwrite,
  input wire logic [7:0]       i_paddr,
  input wire logic [31:0]      i_pwdata,
  input wire logic [31:0]      o_prdata,
  input wire logic             o_pready,
  input wire logic             o_pslverr,
  // Terminals and analog input
  input wire logic             i_raise_pin,
  input wire logic             i_lower_pin,
  input wire logic             i_block_disable_terminal,
  input wire logic             i_power_fail_pin,
  input wire logic [OUT_W-1:0] i_assignable_analog_input,
  // Memory and set value
  input wire logic             i_nvm_ready,
  input wire logic [OUT_W-1:0] i_nvm_data,
  input wire logic             o_nvm_wr_en,
  input wire logic [OUT_W-1:0] o_nvm_wr_data,
  input wire logic [OUT_W-1:0] o_setpoint,
  input wire logic             o_active
);
  logic [4:0] cfg_q;

  // Shadow of the config word; only completed writes count
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      cfg_q <= 5'h00;
    else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == OFS_CONFIG)
      cfg_q <= i_pwdata[4:0];
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // Normal mode moves one count per cycle at most, since ramp time is at least one second
  ramp_rate_a: assert property (
    o_active && $past(o_active) && !cfg_q[CFG_SH] |->
    ($signed(o_setpoint) - $signed($past(o_setpoint))) inside {-1, 0, 1})
    else $error("set value stepped by more than one count");
  load_on_enable_a: assert property (
    $fell(i_block_disable_terminal) |-> ##[1:5] ($rose(o_active) && o_setpoint == i_assignable_analog_input))
    else $error("activation did not load the analog input");
  keep_on_disable_a: assert property (
    $rose(i_block_disable_terminal) && o_active && cfg_q[2:0] == ACT_KEEP |-> ##5 $stable(o_setpoint) [*8])
    else $error("keep action changed the set value");
  ramp_to_zero_a: assert property (
    $rose(i_block_disable_terminal) && o_active && cfg_q[2:0] == ACT_RAMP0 && $signed(o_setpoint) > 50
    |-> ##6 o_setpoint != 16'h0000)
    else $error("ramp to zero jumped");
  jump_to_zero_a: assert property (
    $rose(i_block_disable_terminal) && o_active && cfg_q[2:0] == ACT_JUMP0 |-> ##[1:6] o_setpoint == 16'h0000)
    else $error("jump to zero did not happen at once");
  store_request_a: assert property (
    $rose(i_power_fail_pin) |-> ##[1:8] o_nvm_wr_en)
    else $error("no memory write after power fail");
  store_pulse_a: assert property (
    o_nvm_wr_en |=> !o_nvm_wr_en)
    else $error("memory write longer than one cycle");
  store_data_a: assert property (
    o_nvm_wr_en && $stable(o_setpoint) |-> o_nvm_wr_data == o_setpoint)
    else $error("memory write data differs from set value");
  hold_freeze_a: assert property (
    $fell(o_active) && cfg_q[CFG_SH] && cfg_q[2:0] == ACT_KEEP |=> $stable(o_setpoint) [*8])
    else $error("held value not frozen");
endmodule

bind udsr_top udsr_checker #(.P_CYCLES_PER_SEC(P_CYCLES_PER_SEC)) u_checker (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_raise_pin(i_raise_pin), .i_lower_pin(i_lower_pin), .i_block_disable_terminal(i_block_disable_terminal),
  .i_power_fail_pin(i_power_fail_pin), .i_assignable_analog_input(i_assignable_analog_input),
  .i_nvm_ready(i_nvm_ready), .i_nvm_data(i_nvm_data), .o_nvm_wr_en(o_nvm_wr_en),
  .o_nvm_wr_data(o_nvm_wr_data), .o_setpoint(o_setpoint), .o_active(o_active));

//--- verification/udsr_nvm_model.sv
`timescale 1ns/1ps
module udsr_nvm_model
  import udsr_pkg::*;
#(
  parameter logic [OUT_W-1:0] P_INIT_VALUE  = 16'h01f4,
  parameter int               P_READY_DELAY = 40
)
(
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  // Write side
  input  wire logic             i_wr_en,
  input  wire logic [OUT_W-1:0] i_wr_data,
  // Read side
  output logic                  o_ready,
  output logic      [OUT_W-1:0] o_data,
  output logic      [OUT_W-1:0] o_stored
);
  int wake_cnt = 0;

  // Content survives reset, as the cells survive a mains cycle
  initial o_stored = P_INIT_VALUE;
  always @(posedge i_clock)
  begin
    if (i_wr_en)
      o_stored <= i_wr_data;
    wake_cnt <= i_rst_b ? wake_cnt + 1 : 0;
  end

  // Not valid before wake-up: show the inverse so a stale read is caught
  assign o_ready = (wake_cnt >= P_READY_DELAY);
  assign o_data  = o_ready ? o_stored : ~o_stored;
endmodule

//--- verification/udsr_top_bench.sv
`timescale 1ns/1ps
module udsr_top_bench
  import udsr_pkg::*;
;
  logic             i_clock = 1'b0;
  logic             i_rst_b = 1'b0;
  logic             psel = 1'b0, pen = 1'b0, pwr = 1'b0, raise = 1'b0, lower = 1'b0, dis = 1'b1, pf = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic [OUT_W-1:0] analog = 16'h0000, nvm_data, wr_data, setpoint, stored, hi, lo, snap;
  logic             pready, pslverr, nvm_ready, wr_en, active, err;
  logic [OUT_W-1:0] tgt [6];
  int               lim_t [6] = '{100, 4000, 4000, 1, 1, 4000};
  int               failures = 0, checks = 0, cycles = 0, n;

  // 50 MHz clock
  always #10 i_clock = ~i_clock;

  // Ceiling well above the expected run of about 17000 cycles
  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  // Small cycles-per-second so full ramps fit in the run
  udsr_top #(.P_CYCLES_PER_SEC(16384)) dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_raise_pin(raise),
    .i_lower_pin(lower), .i_block_disable_terminal(dis), .i_power_fail_pin(pf),
    .i_assignable_analog_input(analog), .i_nvm_ready(nvm_ready), .i_nvm_data(nvm_data),
    .o_nvm_wr_en(wr_en), .o_nvm_wr_data(wr_data), .o_setpoint(setpoint), .o_active(active));
  udsr_nvm_model #(.P_INIT_VALUE(16'h01f4), .P_READY_DELAY(40)) nvm (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_en(wr_en), .i_wr_data(wr_data), .o_ready(nvm_ready),
    .o_data(nvm_data), .o_stored(stored));

  // Verdict and end of run
  task automatic tally_and_finish();
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic ok(input string name, input logic cond);
    chk(name, 32'h1, {31'h0, cond});
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge i_clock);
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clock);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clock);
    pen <= 1'b1;
    @(posedge i_clock);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1)
    begin
      @(posedge i_clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic xerr);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
    chk(name, {31'h0, xerr}, {31'h0, err});
  endtask

  // Wait for a set value under a bound; n gives the cycles taken
  task automatic wait_sp(input string name, input logic [OUT_W-1:0] exp, input int lim);
    n = 0;
    while (setpoint !== exp && n < lim)
    begin
      @(posedge i_clock);
      n = n + 1;
    end
    chk(name, 32'(exp), 32'(setpoint));
  endtask

  task automatic do_reset();
    i_rst_b <= 1'b0;
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
  endtask

  // Limit in 0.1 percent steps to output counts
  function automatic logic [OUT_W-1:0] counts(input int lim);
    int p;
    p = (lim * 16777 + 512) >>> 10;
    return p[OUT_W-1:0];
  endfunction

  initial
  begin
    do_reset();
    hi = counts(100);
    lo = counts(-50);
    tgt = '{16'd800, 16'd0, lo, 16'd0, lo, hi};
    wait_sp("init_saved", 16'h01f4, 100);
    rchk("upper_rst", OFS_UPPER, 32'h3e8, 1'b0);
    rchk("lower_rst", OFS_LOWER, 32'h0, 1'b0);
    rchk("accel_rst", OFS_ACCEL, 32'ha, 1'b0);
    rchk("decel_rst", OFS_DECEL, 32'ha, 1'b0);
    rchk("unmapped", 8'h1c, 32'h0, 1'b1);
    apb(1'b1, OFS_ACCEL, 32'h1770);
    rchk("accel_max", OFS_ACCEL, 32'h1388, 1'b0);
    apb(1'b1, OFS_DECEL, 32'h0);
    rchk("decel_min", OFS_DECEL, 32'h1, 1'b0);
    apb(1'b1, OFS_ACCEL, 32'h1);
    apb(1'b1, OFS_DECEL, 32'h2);
    apb(1'b1, OFS_UPPER, 32'h64);
    apb(1'b1, OFS_LOWER, 32'hffffffce);
    // Activation above the upper limit ramps down, never jumps
    analog <= 16'd3000;
    dis <= 1'b0;
    wait_sp("act_load", 16'd3000, 10);
    ok("act_flag", active);
    idle(20);
    ok("act_no_jump", $signed(setpoint) > $signed(hi) && setpoint !== 16'd3000);
    wait_sp("act_to_upper", hi, 4000);
    lower <= 1'b1;
    wait_sp("down_to_lower", lo, 6000);
    ok("down_rate", n > 4700 && n < 5200);
    idle(50);
    chk("down_stop", 32'(lo), 32'(setpoint));
    lower <= 1'b0;
    raise <= 1'b1;
    wait_sp("up_to_upper", hi, 4000);
    ok("up_rate", n > 2350 && n < 2600);
    idle(50);
    chk("up_stop", 32'(hi), 32'(setpoint));
    rchk("output_reg", OFS_OUTPUT, 32'(hi), 1'b0);
    // Move off the limit, then neither and both terminals hold
    raise <= 1'b0;
    lower <= 1'b1;
    idle(100);
    lower <= 1'b0;
    idle(5);
    snap = setpoint;
    ok("moved", snap !== hi);
    idle(100);
    chk("none_hold", 32'(snap), 32'(setpoint));
    raise <= 1'b1;
    lower <= 1'b1;
    idle(100);
    chk("both_hold", 32'(snap), 32'(setpoint));
    raise <= 1'b0;
    lower <= 1'b0;
    // Every deactivation action from an in-limit activation
    analog <= 16'd800;
    dis <= 1'b1;
    idle(6);
    for (int a = 0; a < 6; a++)
    begin
      apb(1'b1, OFS_CONFIG, 32'(a));
      dis <= 1'b0;
      wait_sp("reactivate", 16'd800, 10);
      idle(4);
      dis <= 1'b1;
      idle(8);
      if (lim_t[a] > 100)
        ok("deact_not_jumped", setpoint !== tgt[a]);
      wait_sp("deact_target", tgt[a], lim_t[a]);
      idle(50);
      chk("deact_settled", 32'(tgt[a]), 32'(setpoint));
    end
    pf <= 1'b1;
    idle(10);
    chk("nvm_store", 32'(hi), 32'(stored));
    pf <= 1'b0;
    // Restart with lower-limit init and sample-and-hold mode
    do_reset();
    apb(1'b1, OFS_LOWER, 32'hc8);
    apb(1'b1, OFS_CONFIG, 32'h18);
    wait_sp("init_lower", counts(200), 100);
    analog <= 16'd1200;
    dis <= 1'b0;
    wait_sp("sh_track", 16'd1200, 10);
    raise <= 1'b1;
    idle(20);
    chk("sh_no_ramp", 32'd1200, 32'(setpoint));
    raise <= 1'b0;
    analog <= 16'd1300;
    wait_sp("sh_track2", 16'd1300, 10);
    dis <= 1'b1;
    idle(6);
    analog <= 16'd400;
    idle(20);
    chk("sh_frozen", 32'd1300, 32'(setpoint));
    ok("off_flag", !active);
    tally_and_finish();
  end
endmodule
